//--- pmic_comm_led_adc_regs.sv
// Communication pin, indicator, converter and debug registers
`timescale 1ns/1ps
`include "pmic_defines.svh"

// Function
// - Bit 4 picks pin owner: hardware path at 0, host registers at 1 when bit 8 is also set.
// - Bits 6 and 5 enable left and right pin drivers.
// - Read-only bits 3 and 2 show sampled left and right pin levels.
// - Bits 1 and 0 set driven levels while that driver is enabled.
// - Indicator bits 13 to 10 turn indicators four down to one on.
// - Bits 2:1 give indicator count: 00 two, 01 three, 10 one, 11 four.
// - Indicator bit 0 hands indicators from hardware to register values.
// - Converter result, 12 bits, reads back in bits 15:4.
// - Bits 3:1 route one of eight inputs to the converter.
// - Debug bit 15 resets to 1 and enables the pad glitch filter.
// - Debug bits 11:10 select the charge timeout.
// - Debug bit 9 set by software shows the full-charge indicator pattern while indicators are in hardware mode.
// - Each conversion takes 25 converter clock periods.
// - Control bit 11 enables conversions and result updates.
// - Control bits 7:6 pick converter clock 2, 1, 0.5 or 0.25 MHz.
// - Pin-control bit 8 enables host governance of the pins.
module pmic_comm_led_adc_regs (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire pmic_pkg::reg_req_t    reg_req,
  output logic [15:0]                reg_rdata_q,
  input  wire logic [1:0]            comm_level_in,
  input  wire pmic_pkg::comm_drive_t hw_comm,
  output pmic_pkg::comm_drive_t      comm_pin_q,
  input  wire logic [3:0]            hw_indicator_on,
  input  wire logic [1:0]            hw_indicator_arrangement,
  output logic [3:0]                 indicator_on_q,
  output logic [1:0]                 indicator_arrangement_q,
  input  wire logic [11:0]           conv_result_in,
  output logic [2:0]                 converter_channel_q,
  output logic                       conv_sample_q,
  output logic                       pad_glitch_filter_on_q,
  output logic [1:0]                 charge_timeout_choice_q
);

  // Address match, used for both write and read decode
  function automatic logic addr_hit(input logic [4:0] a,
                                    input logic [4:0] off);
    addr_hit = (a == off);
  endfunction : addr_hit

  logic                 conv_en_q;
  pmic_pkg::conv_clk_t  conv_clk_q;
  logic                 comm_host_mode_on_q;
  logic [1:0]           comm_drive_en_q;
  logic                 comm_owner_select_q;
  logic [1:0]           comm_level_out_q;
  wire logic [1:0]      comm_level_q;
  logic [3:0]           indicator_state_q;
  logic [1:0]           led_arrangement_q;
  logic                 indicator_host_override_q;
  logic [11:0]          conv_result_q;
  logic                 battery_full_q;
  logic                 conv_done;
  logic                 conv_sample;

  // Write strobe decode
  wire logic [15:0] wd     = reg_req.wdata;
  wire logic wr_ctrl = reg_req.wr && addr_hit(reg_req.addr, `ADDR_CTRL);
  wire logic wr_comm = reg_req.wr && addr_hit(reg_req.addr, `ADDR_COMM);
  wire logic wr_led  = reg_req.wr && addr_hit(reg_req.addr, `ADDR_LED);
  wire logic wr_adc  = reg_req.wr && addr_hit(reg_req.addr, `ADDR_ADC);
  wire logic wr_dbg  = reg_req.wr && addr_hit(reg_req.addr, `ADDR_DBG);

  // Register writes; read-only and reserved bits have no storage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_en_q                 <= 1'b0;
      conv_clk_q                <= pmic_pkg::CONV_2MHZ;
      comm_host_mode_on_q       <= 1'b0;
      comm_drive_en_q           <= 2'h0;
      comm_owner_select_q       <= 1'b0;
      comm_level_out_q          <= 2'h0;
      indicator_state_q         <= 4'h0;
      led_arrangement_q         <= 2'h0;
      indicator_host_override_q <= 1'b0;
      converter_channel_q       <= 3'h0;
      pad_glitch_filter_on_q    <= `DBG_FILT_RST;
      charge_timeout_choice_q   <= 2'h0;
      battery_full_q            <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        conv_en_q  <= wd[`CTRL_CONV_EN];
        conv_clk_q <= pmic_pkg::conv_clk_t'(wd[`CTRL_CLK_HI:`CTRL_CLK_LO]);
      end
      if (wr_comm) begin
        comm_host_mode_on_q <= wd[`COMM_HOST_MODE];
        comm_drive_en_q     <= {wd[`COMM_L_DRV], wd[`COMM_R_DRV]};
        comm_owner_select_q <= wd[`COMM_OWNER];
        comm_level_out_q    <= {wd[`COMM_L_OUT], wd[`COMM_R_OUT]};
      end
      if (wr_led) begin
        indicator_state_q         <= wd[`LED_ST_HI:`LED_ST_LO];
        led_arrangement_q         <= wd[`LED_ARR_HI:`LED_ARR_LO];
        indicator_host_override_q <= wd[`LED_OVR];
      end
      if (wr_adc) begin
        converter_channel_q <= wd[`ADC_CH_HI:`ADC_CH_LO];
      end
      if (wr_dbg) begin
        pad_glitch_filter_on_q  <= wd[`DBG_FILT];
        charge_timeout_choice_q <= wd[`DBG_TO_HI:`DBG_TO_LO];
        battery_full_q          <= wd[`DBG_FULL];
      end
    end
  end

  // Pad input filter: a level is taken only after two equal samples
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_pad
      // Local flops keep each process the only writer of its variables
      logic      smp_q;
      logic      lvl_q;
      wire logic agree = (comm_level_in[gi] == smp_q);
      wire logic take  = !pad_glitch_filter_on_q || agree;
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          smp_q <= 1'b0;
          lvl_q <= 1'b0;
        end else begin
          smp_q <= comm_level_in[gi];
          if (take) begin
            lvl_q <= comm_level_in[gi];
          end
        end
      end
      assign comm_level_q[gi] = lvl_q;
    end
  endgenerate

  // Pin owner: host needs both the mode enable and the owner select
  wire logic host_owns = comm_owner_select_q && comm_host_mode_on_q;
  wire pmic_pkg::comm_drive_t comm_next = host_owns ?
    pmic_pkg::comm_drive_t'{level: comm_level_out_q,
                            drive: comm_drive_en_q} : hw_comm;

  // Full-charge pattern lights every indicator in hardware mode
  wire logic [3:0] hw_pattern = battery_full_q ? 4'hF :
                                hw_indicator_on;
  wire logic [3:0] ind_next = indicator_host_override_q ?
                              indicator_state_q : hw_pattern;
  wire logic [1:0] arr_next = indicator_host_override_q ?
                              led_arrangement_q : hw_indicator_arrangement;

  // Output flops for pins and indicators
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      comm_pin_q              <= '0;
      indicator_on_q          <= 4'h0;
      indicator_arrangement_q <= 2'h0;
    end else begin
      comm_pin_q              <= comm_next;
      indicator_on_q          <= ind_next;
      indicator_arrangement_q <= arr_next;
    end
  end

  // Conversion timing lives in the sequencer
  converter_seq u_seq (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .enable     (conv_en_q),
    .clk_choice (conv_clk_q),
    .sample_q   (conv_sample),
    .done_q     (conv_done)
  );

  // Whole result taken in one edge so reads never mix old and new bits
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_result_q <= 12'h000;
      conv_sample_q <= 1'b0;
    end else begin
      conv_sample_q <= conv_sample;
      if (conv_done && conv_en_q) begin
        conv_result_q <= conv_result_in;
      end
    end
  end

  // Read images; reserved bits read zero
  wire logic [15:0] rd_ctrl = {4'h0, conv_en_q, 3'h0, conv_clk_q, 6'h00};
  wire logic [15:0] rd_comm = {7'h00, comm_host_mode_on_q, 1'b0,
                               comm_drive_en_q, comm_owner_select_q,
                               comm_level_q, comm_level_out_q};
  wire logic [15:0] rd_led  = {2'h0, indicator_state_q, 7'h00,
                               led_arrangement_q,
                               indicator_host_override_q};
  wire logic [15:0] rd_adc  = {conv_result_q, converter_channel_q,
                               1'b0};
  wire logic [15:0] rd_dbg  = {pad_glitch_filter_on_q, 3'h0,
                               charge_timeout_choice_q, battery_full_q,
                               9'h000};
  wire logic [4:0] ra = reg_req.addr;
  wire logic [15:0] rd_mux =
    addr_hit(ra, `ADDR_CTRL) ? rd_ctrl :
    addr_hit(ra, `ADDR_COMM) ? rd_comm :
    addr_hit(ra, `ADDR_LED)  ? rd_led  :
    addr_hit(ra, `ADDR_ADC)  ? rd_adc  :
    addr_hit(ra, `ADDR_DBG)  ? rd_dbg  : `REG_ZERO;

  // Read data held until the next read
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= `REG_ZERO;
    end else if (reg_req.rd) begin
      reg_rdata_q <= rd_mux;
    end
  end

  // Host-owned pins follow the register bits one edge later
  host_pin_drive_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ##1 $past(host_owns) |-> comm_pin_q ==
      {$past(comm_level_out_q), $past(comm_drive_en_q)})
    else $error("host-owned pins not following registers");

  // Hardware-owned pins follow the hardware path
  hw_pin_drive_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ##1 !$past(host_owns) |-> comm_pin_q == $past(hw_comm))
    else $error("hardware-owned pins not following hardware path");

  // Override hands indicators to register states
  led_override_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ##1 $past(indicator_host_override_q) |->
      indicator_on_q == $past(indicator_state_q))
    else $error("indicator override not applied");

  // Full battery lights all in hardware mode
  full_pattern_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ##1 ($past(battery_full_q) && !$past(indicator_host_override_q))
      |-> indicator_on_q == 4'hF)
    else $error("full-charge pattern not shown");

  // Result only changes when a conversion ends
  result_atomic_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !$stable(conv_result_q) |-> $past(conv_done))
    else $error("result changed outside conversion end");

  // Writes to the result register leave the result alone
  ro_write_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_adc && !conv_done) |=> $stable(conv_result_q))
    else $error("write disturbed read-only result");

  // Unfiltered pads report the level seen one edge earlier
  pad_bypass_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !pad_glitch_filter_on_q |=> comm_level_q == $past(comm_level_in))
    else $error("pad level not sampled");

  // Debug read shows filter, timeout and full flag in place
  dbg_read_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_req.rd && addr_hit(ra, `ADDR_DBG)) |=>
      reg_rdata_q == {$past(pad_glitch_filter_on_q), 3'h0,
                      $past(charge_timeout_choice_q),
                      $past(battery_full_q), 9'h000})
    else $error("debug register read wrong");

endmodule : pmic_comm_led_adc_regs

//--- pmic_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PMIC_DEFINES_SVH
`define PMIC_DEFINES_SVH

// Register offsets on the internal register port
`define ADDR_CTRL        5'h03
`define ADDR_COMM        5'h0C
`define ADDR_LED         5'h0D
`define ADDR_ADC         5'h0E
`define ADDR_DBG         5'h0F

// Control register fields
`define CTRL_CONV_EN     11
`define CTRL_CLK_HI      7
`define CTRL_CLK_LO      6

// Pin-control register fields
`define COMM_HOST_MODE   8
`define COMM_L_DRV       6
`define COMM_R_DRV       5
`define COMM_OWNER       4
`define COMM_L_IN        3
`define COMM_R_IN        2
`define COMM_L_OUT       1
`define COMM_R_OUT       0

// Indicator register fields
`define LED_ST_HI        13
`define LED_ST_LO        10
`define LED_ARR_HI       2
`define LED_ARR_LO       1
`define LED_OVR          0

// Converter register fields
`define ADC_RES_HI       15
`define ADC_RES_LO       4
`define ADC_CH_HI        3
`define ADC_CH_LO        1

// Debug register fields and reset values
`define DBG_FILT         15
`define DBG_TO_HI        11
`define DBG_TO_LO        10
`define DBG_FULL         9
`define DBG_FILT_RST     1'b1
`define REG_ZERO         16'h0000

// Converter timing: fastest converter clock and conversion length
`define SYS_CLK_KHZ      100000
`define CONV_CLK_KHZ     2000
`define CONV_DIV_BASE    (`SYS_CLK_KHZ / `CONV_CLK_KHZ)
`define CONV_TICKS       25

`endif

//--- pmic_pkg.sv
// Shared types for the control and status register bank
package pmic_pkg;

  // One access on the internal register port
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  // Drive of the two communication pins, index 1 left, 0 right
  typedef struct packed {
    logic [1:0] level;
    logic [1:0] drive;
  } comm_drive_t;

  // Converter clock choices
  typedef enum logic [1:0] {
    CONV_2MHZ, CONV_1MHZ, CONV_500KHZ, CONV_250KHZ
  } conv_clk_t;

  // Conversion sequencer states
  typedef enum logic {
    SEQ_IDLE, SEQ_RUN
  } seq_state_t;

endpackage : pmic_pkg

//--- converter_seq.sv
// Converter clock divider and conversion sequencer
`timescale 1ns/1ps
`include "pmic_defines.svh"

module converter_seq (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              enable,
  input  wire pmic_pkg::conv_clk_t clk_choice,
  output logic                   sample_q,
  output logic                   done_q
);

  logic [8:0]           div_q;
  logic [4:0]           tick_q;
  pmic_pkg::seq_state_t state_q;
  logic [8:0]           div_limit;
  logic                 tick;
  logic                 last_tick;

  // Slower choices double the divide each step
  assign div_limit = 9'(`CONV_DIV_BASE << clk_choice) - 9'h001;
  assign tick      = (state_q == pmic_pkg::SEQ_RUN) && (div_q == div_limit);
  assign last_tick = tick && (tick_q == 5'(`CONV_TICKS - 1));

  // Divider and tick count; disabling drops the running conversion
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= pmic_pkg::SEQ_IDLE;
      div_q    <= 9'h000;
      tick_q   <= 5'h00;
      sample_q <= 1'b0;
      done_q   <= 1'b0;
    end else begin
      sample_q <= 1'b0;
      done_q   <= 1'b0;
      case (state_q)
        pmic_pkg::SEQ_IDLE: begin
          div_q  <= 9'h000;
          tick_q <= 5'h00;
          if (enable) begin
            state_q  <= pmic_pkg::SEQ_RUN;
            sample_q <= 1'b1;
          end
        end
        pmic_pkg::SEQ_RUN: begin
          if (!enable) begin
            state_q <= pmic_pkg::SEQ_IDLE;
          end else if (tick) begin
            div_q <= 9'h000;
            if (last_tick) begin
              tick_q   <= 5'h00;
              done_q   <= 1'b1;
              sample_q <= 1'b1;          // Next conversion starts at once
            end else begin
              tick_q <= tick_q + 5'h01;
            end
          end else begin
            div_q <= div_q + 9'h001;
          end
        end
        default: state_q <= pmic_pkg::SEQ_IDLE;
      endcase
    end
  end

  // A result comes only after the last of the converter periods
  done_at_last_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    done_q |-> $past(tick_q) == 5'(`CONV_TICKS - 1))
    else $error("conversion ended before its last period");

  // No result while the converter is off
  done_needs_en_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    done_q |-> $past(enable))
    else $error("conversion result while converter disabled");

  // Fastest clock: one tick after the divider has passed its top minus one
  fast_tick_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (tick && enable && clk_choice == pmic_pkg::CONV_2MHZ)
      |-> $past(div_q) == 9'(`CONV_DIV_BASE - 2))
    else $error("converter clock divide wrong");

endmodule : converter_seq

//--- reg_host.sv
// Host register master model for the bank's internal port
`timescale 1ns/1ps
`include "pmic_defines.svh"

module reg_host (
  input  wire logic          sys_clk,
  output pmic_pkg::reg_req_t reg_req
);
  initial reg_req = '0;

  // One access per call, launched and dropped on falling edges;
  // released lines show inverted values so stale data is not trusted
  task automatic put(input logic w, input logic r, input logic [4:0] a,
                     input logic [15:0] d);
    @(negedge sys_clk);
    reg_req <= '{wr: w, rd: r, addr: a, wdata: d};
    @(negedge sys_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : put

  // Reserved indicator bits always go out as zero
  task automatic write(input logic [4:0] a, input logic [15:0] d);
    put(1'b1, 1'b0, a, (a == `ADDR_LED) ? (d & 16'h3C07) : d);
  endtask : write

  // Sends data untouched, for writes aimed at read-only bits
  task automatic write_raw(input logic [4:0] a, input logic [15:0] d);
    put(1'b1, 1'b0, a, d);
  endtask : write_raw

  task automatic read(input logic [4:0] a);
    put(1'b0, 1'b1, a, 16'h0000);
  endtask : read
endmodule : reg_host

//--- testbench.sv
// Self-checking bench for the register bank
`timescale 1ns/1ps
`include "pmic_defines.svh"

module testbench;
  logic                  sys_clk = 1'b0;
  logic                  rst_n = 1'b0;
  pmic_pkg::reg_req_t    reg_req;
  logic [15:0]           reg_rdata_q;
  logic [1:0]            comm_level_in = 2'h0;
  pmic_pkg::comm_drive_t hw_comm = '0;
  pmic_pkg::comm_drive_t comm_pin_q;
  logic [3:0]            hw_ind = 4'h0;
  logic [1:0]            hw_arr = 2'h0;
  logic [3:0]            ind_q;
  logic [1:0]            arr_q;
  logic [11:0]           res_in = 12'h000;
  logic [2:0]            ch_q;
  logic                  smp_q;
  logic                  filt_q;
  logic [1:0]            to_q;
  logic [31:0]           seed = 32'h4FA13443;
  logic [15:0]           exp_q[$];
  logic                  rd_seen = 1'b0;
  logic [15:0]           v;
  logic [15:0]           r;
  int                    err_total = 0;
  int                    n_tests = 0;
  int                    n;
  localparam logic [4:0] ZADDR [5] = '{5'h00, 5'h03, 5'h0C, 5'h0D, 5'h0E};

  always #5 sys_clk = ~sys_clk;

  reg_host i_reg_host (.sys_clk(sys_clk), .reg_req(reg_req));

  pmic_comm_led_adc_regs i_pmic_comm_led_adc_regs (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rdata_q(reg_rdata_q), .comm_level_in(comm_level_in),
    .hw_comm(hw_comm), .comm_pin_q(comm_pin_q),
    .hw_indicator_on(hw_ind), .hw_indicator_arrangement(hw_arr),
    .indicator_on_q(ind_q), .indicator_arrangement_q(arr_q),
    .conv_result_in(res_in), .converter_channel_q(ch_q),
    .conv_sample_q(smp_q), .pad_glitch_filter_on_q(filt_q),
    .charge_timeout_choice_q(to_q));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic wrap_up();
    // A read never answered is a mismatch too
    if (exp_q.size() != 0) begin
      err_total++;
      $display("unexpected reads left at %0t: got %h exp %h", $time,
               exp_q.size(), 0);
    end
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  task automatic check_rd(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected read at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check_rd

  task automatic check_out(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected output at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check_out

  // Expected read image is queued before the strobe goes out
  task automatic rd_exp(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    i_reg_host.read(a);
  endtask : rd_exp

  // Bounded so a stalled sequencer cannot hang the run
  task automatic wait_pulse(output int cnt);
    cnt = 0;
    do begin
      @(negedge sys_clk);
      cnt++;
    end while (smp_q !== 1'b1 && cnt < 12000);
    if (cnt >= 12000) begin
      err_total++;
      $display("unexpected timeout at %0t: got %h exp %h", $time, 0, 1);
      wrap_up();
    end
  endtask : wait_pulse

  // Read data settles one edge after the strobe is taken
  always @(posedge sys_clk) rd_seen <= reg_req.rd & rst_n;
  always @(negedge sys_clk) begin
    if (rd_seen && exp_q.size() > 0) begin
      check_rd(reg_rdata_q, exp_q.pop_front());
    end
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    // Reset images, unmapped offset included
    check_out(16'(filt_q), 16'h0001);
    rd_exp(`ADDR_DBG, 16'h8000);
    for (int i = 0; i < 5; i++) begin
      rd_exp(ZADDR[i], 16'h0000);
    end
    // Every timeout code, full flag toggled, filter bypassed
    for (int t = 0; t < 4; t++) begin
      v = {4'h0, t[1:0], t[0], 9'h000};
      i_reg_host.write(`ADDR_DBG, v);
      check_out(16'(to_q), 16'(t[1:0]));
      check_out(16'(filt_q), 16'h0000);
      rd_exp(`ADDR_DBG, v);
    end
    // Full flag forces the full pattern in hardware mode; override then hands indicators to register states
    hw_ind = 4'(xs());
    hw_arr = 2'(xs());
    i_reg_host.write(`ADDR_DBG, 16'h0200);
    repeat (2) @(negedge sys_clk);
    check_out(16'(ind_q), 16'h000F);
    i_reg_host.write(`ADDR_DBG, 16'h0000);
    repeat (2) @(negedge sys_clk);
    check_out(16'({ind_q, arr_q}), 16'({hw_ind, hw_arr}));
    for (int m = 0; m < 4; m++) begin
      r = 16'(xs());
      v = {2'b00, r[3:0], 7'h00, m[1:0], 1'b1};
      hw_ind = ~r[3:0];
      i_reg_host.write(`ADDR_LED, v | 16'hC3F8);
      repeat (2) @(negedge sys_clk);
      check_out(16'(ind_q), 16'(v[13:10]));
      check_out(16'(arr_q), 16'(m[1:0]));
      rd_exp(`ADDR_LED, v);
    end
    // Pins follow hardware until the host takes them
    hw_comm = 4'(xs());
    repeat (2) @(negedge sys_clk);
    check_out(16'(comm_pin_q), 16'(hw_comm));
    for (int k = 0; k < 4; k++) begin
      r = 16'(xs());
      v = {7'h00, 1'b1, 1'b0, r[6:5], 1'b1, 2'b00, r[1:0]};
      hw_comm = ~r[3:0];
      i_reg_host.write(`ADDR_COMM, v);
      repeat (2) @(negedge sys_clk);
      check_out(16'(comm_pin_q), 16'({v[1:0], v[6:5]}));
      rd_exp(`ADDR_COMM, v);
    end
    i_reg_host.write(`ADDR_COMM, v & 16'hFEFF);
    repeat (2) @(negedge sys_clk);
    check_out(16'(comm_pin_q), 16'(hw_comm));
    comm_level_in = 2'b10;
    repeat (3) @(negedge sys_clk);
    rd_exp(`ADDR_COMM, (v & 16'h00F3) | 16'h0008);
    comm_level_in = 2'b01;
    i_reg_host.write_raw(`ADDR_COMM, (v & 16'h00FF) | 16'h000C);
    repeat (3) @(negedge sys_clk);
    rd_exp(`ADDR_COMM, (v & 16'h00F3) | 16'h0004);
    // Filter on: a one-cycle glitch is dropped, a steady level passes
    i_reg_host.write(`ADDR_DBG, 16'h8000);
    comm_level_in = 2'b11;
    @(negedge sys_clk);
    comm_level_in = 2'b01;
    repeat (2) @(negedge sys_clk);
    rd_exp(`ADDR_COMM, (v & 16'h00F3) | 16'h0004);
    comm_level_in = 2'b11;
    repeat (3) @(negedge sys_clk);
    rd_exp(`ADDR_COMM, (v & 16'h00F3) | 16'h000C);
    // Every channel; result bits in the write are ignored
    for (int c = 0; c < 8; c++) begin
      i_reg_host.write_raw(`ADDR_ADC, {12'hFFF, c[2:0], 1'b1});
      check_out(16'(ch_q), 16'(c[2:0]));
      rd_exp(`ADDR_ADC, {12'h000, c[2:0], 1'b0});
    end
    // Conversion period for each converter clock choice
    for (int k = 0; k < 4; k++) begin
      res_in = 12'(xs());
      i_reg_host.write(`ADDR_CTRL, {4'h0, 1'b1, 3'h0, k[1:0], 6'h00});
      rd_exp(`ADDR_CTRL, {4'h0, 1'b1, 3'h0, k[1:0], 6'h00});
      wait_pulse(n);
      wait_pulse(n);
      check_out(n[15:0], 16'(1250 << k));
      rd_exp(`ADDR_ADC, {res_in, 3'h7, 1'b0});
      i_reg_host.write(`ADDR_CTRL, 16'h0000);
    end
    // Disabled converter neither samples nor updates
    v = {res_in, 4'hE};
    res_in = ~res_in;
    n = 0;
    repeat (3000) begin
      @(negedge sys_clk);
      n += int'(smp_q === 1'b1);
    end
    check_out(n[15:0], 16'h0000);
    rd_exp(`ADDR_ADC, v);
    repeat (3) @(negedge sys_clk);
    wrap_up();
  end
endmodule : testbench
